// File: hdl/osc_cfg_host.sv
`timescale 1ns/1ps
module osc_cfg_host
  import osc_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h55, // Arbitrary value
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  osc_i2c_if.host bus,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out
);
  localparam int QW = $clog2(QUARTER);

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } host_e;

  typedef struct packed {
    host_e st;
    logic [QW-1:0] qc;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [2:0] step;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rdn;
    logic [6:0] taddr;
    logic [7:0] regn;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic busy;
    logic nack;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic [1:0] sda_s;
  } state_s;

  state_s q;
  state_s d;

  // Byte sent at each step of a transaction
  function automatic logic [7:0] step_byte(input state_s s, input logic [2:0] n);
    case (n)
      3'h0: return {s.taddr, 1'b0};
      3'h1: return s.regn;
      3'h2: return s.wdat;
      default: return {s.taddr, 1'b1};
    endcase
  endfunction

  logic tick;
  logic rx_mode;
  logic last;

  assign tick = (q.qc == QW'(QUARTER - 1));
  assign rx_mode = (q.step == 3'h4);
  assign last = q.rdn ? rx_mode : (q.step == 3'h2);

  always_comb begin
    d = q;
    d.sda_s = {q.sda_s[0], bus.sda};
    // Command port
    if (rd_in) begin
      case (addr_in)
        HREG_REGNUM: d.rdata = q.regn;
        HREG_WDATA: d.rdata = q.wdat;
        HREG_STATUS: d.rdata = {6'h00, q.nack, q.busy};
        HREG_RDATA: d.rdata = q.rdat;
        HREG_TADDR: d.rdata = {1'b0, q.taddr};
        default: d.rdata = 8'h00;
      endcase
    end
    if (wr_in) begin
      case (addr_in)
        HREG_REGNUM: d.regn = wdata_in;
        HREG_WDATA: d.wdat = wdata_in;
        HREG_TADDR: d.taddr = wdata_in[6:0];
        HREG_CMD: begin
          if (wdata_in[CMD_GO_BIT] && !q.busy) begin
            d.busy = 1'b1;
            d.nack = 1'b0;
            d.rdn = wdata_in[CMD_READ_BIT];
            d.step = 3'h0;
            d.st = H_START;
            d.ph = 2'h0;
            d.qc = '0;
          end
        end
        default: begin
        end
      endcase
    end
    // Quarter-bit timing
    if (q.st != H_IDLE) begin
      d.qc = tick ? '0 : q.qc + QW'(1);
      if (tick) begin
        d.ph = q.ph + 2'h1;
      end
    end
    if (tick) begin
      case (q.st)
        H_START: begin
          // R12 - start or repeated start
          case (q.ph)
            2'h0: begin
              d.scl_oe = 1'b1;
              d.sda_oe = 1'b0;
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.st = H_BIT;
              d.bitn = 4'h0;
              d.tx = step_byte(q, q.step);
            end
          endcase
        end
        H_BIT: begin
          case (q.ph)
            // R13 - released at the last ack slot
            2'h0: d.sda_oe = !rx_mode && (q.bitn != 4'h8) && !q.tx[7];
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitn == 4'h8) begin
                // R14 - high at ack means refused
                if (!rx_mode && q.sda_s[1]) begin
                  d.nack = 1'b1;
                end
              end else begin
                d.rx = {q.rx[6:0], q.sda_s[1]};
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              if (q.bitn != 4'h8) begin
                // R9 - next bit, MSB first
                d.bitn = q.bitn + 4'h1;
                d.tx = {q.tx[6:0], 1'b0};
              end else if (q.nack || last) begin
                // R13 - stop after last byte
                d.st = H_STOP;
                if (rx_mode) begin
                  d.rdat = q.rx;
                end
              end else if (q.rdn && q.step == 3'h1) begin
                // R12 - turn round for the read
                d.step = 3'h3;
                d.st = H_START;
              end else begin
                // R11 - next byte of the transfer
                d.step = q.step + 3'h1;
                d.bitn = 4'h0;
                d.tx = step_byte(q, q.step + 3'h1);
              end
            end
          endcase
        end
        H_STOP: begin
          case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              d.st = H_IDLE;
              d.busy = 1'b0;
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.st <= H_IDLE;
      q.taddr <= TARGET_ADDR;
      q.sda_s <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // R1 - hold, bank and apply orders come from software
  assign bus.m_scl_out = 1'b0;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_oe = q.sda_oe;
  assign rdata_out = q.rdata;
endmodule

// File: hdl/osc_cfg_target.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - Host sets hold bit before reconfiguring
// R2 - Host writes new bank while held
// R3 - Host releases hold, then applies within window
// R4 - Late apply times out, defaults restored
// R5 - Apply restarts oscillator with new values
// R6 - Tight grade uses upper bank
// R7 - Multiplier is integer over two to 28
// R8 - I2C target up to fast mode
// R9 - Bytes of eight bits, MSB first
// R10 - Reads and writes take many bytes
// R11 - Write: address, pointer, data, stop
// R12 - Read: pointer, repeated start, read address
// R13 - Host acks all but last, NACK, stop
// R14 - Ack is low, NACK high ends read
// R15 - Target address is fixed
// R16 - Clock input only, data open drain
// R17 - High-speed divider code mapping
// R18 - Output divider is ratio minus one
// R19 - First two registers pack dividers and multiplier
// R20 - Multiplier 38 bits, ten integer bits
// R21 - Byte address advances after each byte
module osc_cfg_target
  import osc_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h55, // Arbitrary value
  parameter int TIMEOUT_CYCLES = APPLY_WINDOW_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  osc_i2c_if.device bus,
  input wire logic grade_tight_in,
  output logic [3:0] hs_ratio_out,
  output logic [7:0] od_ratio_out,
  output logic [MULT_W-1:0] freq_multiplier_out,
  output logic oscillator_hold_out,
  output logic calib_start_out,
  output logic config_revert_out
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_ADDR = 3'b001,
    T_ADDR_ACK = 3'b010,
    T_PTR = 3'b011,
    T_DATA_ACK = 3'b100,
    T_WDATA = 3'b101,
    T_RDATA = 3'b110,
    T_RACK = 3'b111
  } tgt_e;

  typedef struct packed {
    tgt_e st;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] grade_s;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic done;
    logic rw;
    logic [7:0] ptr;
    logic sda_oe;
    logic [47:0] bank_std;
    logic [47:0] bank_tight;
    logic hold;
    logic apply;
    logic armed;
    logic [TW-1:0] timer;
    logic [3:0] hs_r;
    logic [7:0] od_r;
    logic [MULT_W-1:0] mult;
    logic calib;
    logic revert;
  } state_s;

  state_s q;
  state_s d;

  // Address falls inside a six-byte bank
  function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + CFG_BYTES);
  endfunction

  // Byte slot in a bank, first register at the top
  function automatic logic [2:0] slot(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] off;
    off = a - base;
    return 3'(3'd5 - off[2:0]);
  endfunction

  // Register read mux, reserved addresses read zero
  function automatic logic [7:0] rd_reg(input state_s s, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (in_bank(a, REG_BANK_STD)) begin
      r = s.bank_std[8 * slot(a, REG_BANK_STD) +: 8];
    end else if (in_bank(a, REG_BANK_TIGHT)) begin
      r = s.bank_tight[8 * slot(a, REG_BANK_TIGHT) +: 8];
    end else if (a == REG_CTRL) begin
      r[APPLY_BIT] = s.apply;
    end else if (a == REG_HOLD) begin
      r[HOLD_BIT] = s.hold;
    end
    return r;
  endfunction

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic sda_v;
  logic tight;
  logic [47:0] sel_bank;
  logic [7:0] rd_next;
  logic [7:0] rd_cur;

  // R8 - synced edges bound the bit rate
  // Edge and condition detection on synchronised lines
  assign scl_rise = q.scl_s[1] && !q.scl_s[2];
  assign scl_fall = !q.scl_s[1] && q.scl_s[2];
  assign sda_v = q.sda_s[1];
  assign start_cond = q.scl_s[1] && q.scl_s[2] && q.sda_s[2] && !q.sda_s[1];
  assign stop_cond = q.scl_s[1] && q.scl_s[2] && !q.sda_s[2] && q.sda_s[1];
  // R6 - bank selection by grade
  assign tight = q.grade_s[1];
  assign sel_bank = tight ? q.bank_tight : q.bank_std;
  assign rd_next = rd_reg(q, q.ptr + 8'h01);
  assign rd_cur = rd_reg(q, q.ptr);

  // Next-state logic
  always_comb begin
    d = q;
    d.calib = 1'b0;
    d.revert = 1'b0;
    // R16 - clock sampled only, data driven low
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    d.grade_s = {q.grade_s[0], grade_tight_in};

    // R4 - window timer after hold release
    if (q.armed) begin
      d.timer = q.timer + TW'(1);
      if (q.timer == TW'(TIMEOUT_CYCLES - 1) && !q.apply) begin
        d.armed = 1'b0;
        d.revert = 1'b1;
        if (tight) begin
          d.bank_tight = CFG_DEFAULT;
        end else begin
          d.bank_std = CFG_DEFAULT;
        end
        d.hs_r = hs_ratio(CFG_DEFAULT[HS_MSB:HS_LSB]);
        d.od_r = od_ratio(CFG_DEFAULT[OD_MSB:OD_LSB]);
        d.mult = CFG_DEFAULT[MULT_W-1:0];
      end
    end
    // R5 - calibration loads the selected bank
    if (q.apply) begin
      d.apply = 1'b0;
      d.armed = 1'b0;
      d.calib = 1'b1;
      // R17 - high-speed divider decode
      d.hs_r = hs_ratio(sel_bank[HS_MSB:HS_LSB]);
      // R18 - output divider decode
      d.od_r = od_ratio(sel_bank[OD_MSB:OD_LSB]);
      // R7 - fixed-point multiplier passed raw
      d.mult = sel_bank[MULT_W-1:0];
    end

    // Serial target state machine
    if (stop_cond) begin
      d.st = T_IDLE;
      d.sda_oe = 1'b0;
    end else if (start_cond) begin
      // R12 - repeated start restarts addressing
      d.st = T_ADDR;
      d.cnt = 3'h0;
      d.done = 1'b0;
      d.sda_oe = 1'b0;
    end else begin
      case (q.st)
        T_ADDR, T_PTR, T_WDATA: begin
          if (scl_rise) begin
            // R9 - shift in MSB first
            d.sh = {q.sh[6:0], sda_v};
            d.cnt = q.cnt + 3'h1;
            d.done = (q.cnt == 3'h7);
          end else if (scl_fall && q.done) begin
            d.done = 1'b0;
            d.cnt = 3'h0;
            // R14 - acknowledge by pulling data low
            d.sda_oe = 1'b1;
            if (q.st == T_ADDR) begin
              // R15 - fixed address match
              if (q.sh[7:1] == TARGET_ADDR) begin
                d.rw = q.sh[0];
                d.st = T_ADDR_ACK;
              end else begin
                d.sda_oe = 1'b0;
                d.st = T_IDLE;
              end
            end else if (q.st == T_PTR) begin
              d.ptr = q.sh;
              d.st = T_DATA_ACK;
            end else begin
              // R11 - data byte stored and acknowledged
              d.st = T_DATA_ACK;
              // R21 - pointer advances after a write
              d.ptr = q.ptr + 8'h01;
              if (in_bank(q.ptr, REG_BANK_STD)) begin
                // R19 - byte packing of the bank
                d.bank_std[8 * slot(q.ptr, REG_BANK_STD) +: 8] = q.sh;
              end else if (in_bank(q.ptr, REG_BANK_TIGHT)) begin
                // R20 - multiplier spread over the bank
                d.bank_tight[8 * slot(q.ptr, REG_BANK_TIGHT) +: 8] = q.sh;
              end else if (q.ptr == REG_CTRL) begin
                d.apply = q.apply | q.sh[APPLY_BIT];
              end else if (q.ptr == REG_HOLD) begin
                d.hold = q.sh[HOLD_BIT];
                // R4 - hold release opens the window
                if (q.hold && !q.sh[HOLD_BIT]) begin
                  d.armed = 1'b1;
                  d.timer = '0;
                end else if (q.sh[HOLD_BIT]) begin
                  d.armed = 1'b0;
                end
              end
            end
          end
        end
        T_ADDR_ACK: begin
          if (scl_fall) begin
            if (q.rw) begin
              d.sh = rd_cur;
              d.sda_oe = !rd_cur[7];
              d.st = T_RDATA;
            end else begin
              d.sda_oe = 1'b0;
              d.st = T_PTR;
            end
          end
        end
        T_DATA_ACK: begin
          // R10 - further data bytes accepted
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.st = T_WDATA;
          end
        end
        T_RDATA: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 3'h1;
            d.done = (q.cnt == 3'h7);
          end else if (scl_fall) begin
            if (q.done) begin
              d.done = 1'b0;
              d.cnt = 3'h0;
              d.sda_oe = 1'b0;
              d.st = T_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe = !q.sh[6];
            end
          end
        end
        T_RACK: begin
          if (scl_rise) begin
            // R14 - high at ack slot ends the read
            d.done = !sda_v;
          end else if (scl_fall) begin
            // R21 - pointer advances after a read
            d.ptr = q.ptr + 8'h01;
            d.done = 1'b0;
            if (q.done) begin
              // R10 - next read byte
              d.sh = rd_next;
              d.sda_oe = !rd_next[7];
              d.st = T_RDATA;
            end else begin
              d.st = T_IDLE;
            end
          end
        end
        default: begin
          d.st = T_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q <= '0;
      q.st <= T_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.bank_std <= CFG_DEFAULT;
      q.bank_tight <= CFG_DEFAULT;
      q.hs_r <= hs_ratio(CFG_DEFAULT[HS_MSB:HS_LSB]);
      q.od_r <= od_ratio(CFG_DEFAULT[OD_MSB:OD_LSB]);
      q.mult <= CFG_DEFAULT[MULT_W-1:0];
    end else begin
      q <= d;
    end
  end

  // Outputs straight from state
  assign bus.d_sda_out = 1'b0;
  assign bus.d_sda_oe = q.sda_oe;
  assign hs_ratio_out = q.hs_r;
  assign od_ratio_out = q.od_r;
  assign freq_multiplier_out = q.mult;
  assign oscillator_hold_out = q.hold;
  assign calib_start_out = q.calib;
  assign config_revert_out = q.revert;
endmodule

// File: hdl/osc_i2c_if.sv
`timescale 1ns/1ps
interface osc_i2c_if;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic scl;
  logic sda;

  // Wired-AND of the open-drain drivers with pull-ups
  assign scl = m_scl_oe ? m_scl_out : 1'b1;
  assign sda = (m_sda_oe ? m_sda_out : 1'b1) & (d_sda_oe ? d_sda_out : 1'b1);

  modport device(input scl, input sda, output d_sda_out, output d_sda_oe);
  modport host(input scl, input sda, output m_scl_out, output m_scl_oe,
               output m_sda_out, output m_sda_oe);
endinterface

// File: hdl/osc_pkg.sv
package osc_pkg;
  // Clock and bus timing
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int I2C_RATE_HZ = 400_000;
  localparam int QUARTER_CYC = (SYS_CLK_HZ + 4 * I2C_RATE_HZ - 1) / (4 * I2C_RATE_HZ);
  localparam int APPLY_WINDOW_MS = 10;
  localparam int APPLY_WINDOW_CYC = (SYS_CLK_HZ / 1000) * APPLY_WINDOW_MS;

  // Oscillator register map
  localparam logic [7:0] REG_BANK_STD = 8'h07;
  localparam logic [7:0] REG_BANK_TIGHT = 8'h0D;
  localparam logic [7:0] CFG_BYTES = 8'h06;
  localparam logic [7:0] REG_CTRL = 8'h87;
  localparam logic [7:0] REG_HOLD = 8'h89;
  localparam int APPLY_BIT = 6;
  localparam int HOLD_BIT = 4;

  // Bank layout, first register in the top byte
  localparam int HS_MSB = 47;
  localparam int HS_LSB = 45;
  localparam int OD_MSB = 44;
  localparam int OD_LSB = 38;
  localparam int MULT_W = 38;
  localparam int MULT_FRAC_BITS = 28;
  localparam logic [47:0] CFG_DEFAULT = 48'h01C2_BC01_1EB8;

  // Host command port map
  localparam logic [7:0] HREG_CMD = 8'h00;
  localparam logic [7:0] HREG_REGNUM = 8'h01;
  localparam logic [7:0] HREG_WDATA = 8'h02;
  localparam logic [7:0] HREG_STATUS = 8'h03;
  localparam logic [7:0] HREG_RDATA = 8'h04;
  localparam logic [7:0] HREG_TADDR = 8'h05;
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  // High-speed divider code to ratio, zero for unused codes
  function automatic logic [3:0] hs_ratio(input logic [2:0] code);
    case (code)
      3'b000: return 4'h4;
      3'b001: return 4'h5;
      3'b010: return 4'h6;
      3'b011: return 4'h7;
      3'b101: return 4'h9;
      3'b111: return 4'hB;
      default: return 4'h0;
    endcase
  endfunction

  // Output divider field to ratio, odd ratios above one rounded up
  function automatic logic [7:0] od_ratio(input logic [6:0] f);
    logic [7:0] r;
    r = {1'b0, f} + 8'h01;
    if (f != 7'h00 && !f[0]) begin
      r = r + 8'h01;
    end
    return r;
  endfunction
endpackage

// File: testbench/i2c_oscillator_freq_config_port_bench.sv
`timescale 1ns/1ps
module i2c_oscillator_freq_config_port_bench;
  import osc_pkg::*;
  localparam int TMO = 2000;
  logic sys_clk_in = 1'b0, rst_b_in = 1'b0, grade_tight_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out, st, rv;
  logic [3:0] hs_ratio_out;
  logic [7:0] od_ratio_out;
  logic [MULT_W-1:0] freq_multiplier_out;
  logic oscillator_hold_out, calib_start_out, config_revert_out;
  int error_cnt = 0, n_tests = 0, n_cal = 0, n_rev = 0;

  osc_i2c_if bus_if ();
  osc_cfg_host #(.QUARTER(4)) osc_cfg_host_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .bus(bus_if), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out));
  osc_cfg_target #(.TIMEOUT_CYCLES(TMO)) osc_cfg_target_inst (.sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in), .bus(bus_if), .grade_tight_in(grade_tight_in),
    .hs_ratio_out(hs_ratio_out), .od_ratio_out(od_ratio_out),
    .freq_multiplier_out(freq_multiplier_out), .oscillator_hold_out(oscillator_hold_out),
    .calib_start_out(calib_start_out), .config_revert_out(config_revert_out));
  osc_i2c_properties osc_i2c_properties_inst (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .scl(bus_if.scl), .sda(bus_if.sda), .m_scl_out(bus_if.m_scl_out),
    .m_sda_out(bus_if.m_sda_out), .d_sda_out(bus_if.d_sda_out), .d_sda_oe(bus_if.d_sda_oe));

  // Clock generator
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  // Count one-cycle calibration and revert pulses
  always @(posedge sys_clk_in) begin
    if (calib_start_out === 1'b1) n_cal++;
    if (config_revert_out === 1'b1) n_rev++;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hw(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic hr(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // One single-byte transfer, status left in st, read data in rv
  task automatic xfer(input logic rd, input logic [7:0] r, input logic [7:0] d);
    int i;
    hw(HREG_REGNUM, r);
    hw(HREG_WDATA, d);
    hw(HREG_CMD, {6'h00, rd, 1'b1});
    st = 8'h01;
    for (i = 0; i < 3000 && st[STAT_BUSY_BIT] !== 1'b0; i++) hr(HREG_STATUS, st);
    chk(st[STAT_BUSY_BIT], 1'b0);
    hr(HREG_RDATA, rv);
  endtask

  // Hold, write a whole bank, release
  task automatic load_bank(input logic [7:0] base, input logic [47:0] cfg);
    int k;
    xfer(1'b0, REG_HOLD, 8'h10);
    for (k = 0; k < 6; k++) xfer(1'b0, base + 8'(k), cfg[47-8*k -: 8]);
    xfer(1'b0, REG_HOLD, 8'h00);
  endtask

  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog well past the expected run length
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    error_cnt++;
    results();
  end

  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    chk(hs_ratio_out, 4'h4);
    chk(od_ratio_out, 8'h08);
    chk(freq_multiplier_out, 38'h2_BC01_1EB8);
    hr(8'h3F, rv);
    chk(rv, 8'h00);
    $display("test defaults done");
    // Standard bank: hs code 101, even field 6 rounds up to 8
    load_bank(REG_BANK_STD, 48'hA1AD_D1E1_2788);
    xfer(1'b1, 8'h09, 8'h00);
    chk(rv, 8'hD1);
    chk(st[STAT_NACK_BIT], 1'b0);
    chk(hs_ratio_out, 4'h4);
    xfer(1'b0, REG_CTRL, 8'h40);
    chk(n_cal, 1);
    chk(hs_ratio_out, 4'h9);
    chk(od_ratio_out, 8'h08);
    chk(freq_multiplier_out, 38'h2D_D1E1_2788);
    $display("test standard bank done");
    // Tight grade takes the upper bank
    grade_tight_in <= 1'b1;
    load_bank(REG_BANK_TIGHT, 48'hE001_2345_6789);
    xfer(1'b0, REG_CTRL, 8'h40);
    chk(n_cal, 2);
    chk(hs_ratio_out, 4'hB);
    chk(od_ratio_out, 8'h01);
    chk(freq_multiplier_out, 38'h01_2345_6789);
    $display("test tight bank done");
    // Apply too late: defaults come back
    grade_tight_in <= 1'b0;
    xfer(1'b0, REG_HOLD, 8'h10);
    chk(oscillator_hold_out, 1'b1);
    xfer(1'b0, REG_HOLD, 8'h00);
    repeat (TMO - 600) @(posedge sys_clk_in);
    chk(n_rev, 0);
    repeat (800) @(posedge sys_clk_in);
    chk(n_rev, 1);
    chk(hs_ratio_out, 4'h4);
    chk(freq_multiplier_out, 38'h2_BC01_1EB8);
    xfer(1'b1, 8'h09, 8'h00);
    chk(rv, 8'hBC);
    $display("test late apply done");
    // Wrong target address is not acknowledged
    hw(HREG_TADDR, 8'h22);
    xfer(1'b0, REG_HOLD, 8'h10);
    chk(st[STAT_NACK_BIT], 1'b1);
    chk(oscillator_hold_out, 1'b0);
    hw(HREG_TADDR, 8'h55);
    $display("test address mismatch done");
    results();
  end
endmodule

// File: testbench/osc_i2c_properties.sv
`timescale 1ns/1ps
module osc_i2c_properties (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic m_scl_out,
  input wire logic m_sda_out,
  input wire logic d_sda_out,
  input wire logic d_sda_oe
);
  logic [3:0] bit_q;
  logic [7:0] byte_q;
  logic rd_q;
  logic scl_q;
  logic sda_q;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Bit and byte position since the last start, plus direction bit
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bit_q <= 4'h0;
      byte_q <= 8'h00;
      rd_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin
        bit_q <= 4'h0;
        byte_q <= 8'h00;
      end else if (scl && !scl_q) begin
        bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
        byte_q <= (bit_q == 4'h8) ? byte_q + 8'h01 : byte_q;
        rd_q <= (bit_q == 4'h7 && byte_q == 8'h00) ? sda : rd_q;
      end
    end
  end

  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence

  property p_open_drain;
    !(m_scl_out || m_sda_out || d_sda_out);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain output driven high");
  property p_dev_hold;
    $changed(d_sda_oe) |-> !scl && !$past(scl);
  endproperty
  a_dev_hold: assert property (p_dev_hold)
    else $error("target changed data while clock high");
  property p_scl_high;
    $rose(scl) |-> scl [*4];
  endproperty
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  property p_scl_low;
    $fell(scl) |-> !scl [*4];
  endproperty
  a_scl_low: assert property (p_scl_low)
    else $error("clock low phase too short");
  property p_start_clk;
    s_start |-> ##[1:40] !scl;
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("no clock after start");
  property p_stop_idle;
    s_stop |-> (scl && sda) [*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");
  property p_ack_slot;
    $rose(scl) && d_sda_oe |-> bit_q == 4'h8 || (rd_q && byte_q != 8'h00);
  endproperty
  a_ack_slot: assert property (p_ack_slot)
    else $error("target drove data outside its slots");
  property p_rd_release;
    $rose(scl) && bit_q == 4'h8 && rd_q && byte_q != 8'h00 |-> !d_sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("target held data during host acknowledge");
endmodule
